// File: rtl/ssws_top.sv
// frame receiver, sleep/wake control and msb-first lf bit sender
// assumes an spi master host on the pins and a 100 MHz system clock
`timescale 1ns/1ps
`default_nettype none

module ssws_top
	import ssws_pkg::*;
(
	input  wire logic            SYS_CLK,
	input  wire logic            RESET,
	input  wire logic            SCLK,
	input  wire logic            CHIP_SELECT_LOW_N,
	input  wire logic            SDI,
	output logic                 SDO,
	output logic                 SDO_OE_N,
	output logic                 LF_OUT,
	output logic                 LF_OE_N,
	output ssws_status_type      STATUS
);

	// ****************************************
	// state
	// ****************************************
	ssws_state_type s_q;
	ssws_state_type s_d;
	logic sclk_rise;
	logic cs_low;
	logic cs_rise;
	logic frame_ok;
	logic [2:0] op;

	// a rise counts when the second stage is high and the third still low; cs_low needs both low
	assign sclk_rise = s_q.sclk_sync[1] & ~s_q.sclk_sync[2];
	assign cs_low    = ~s_q.cs_sync[1] & ~s_q.cs_sync[2];
	assign cs_rise   = s_q.cs_sync[1] & ~s_q.cs_sync[2];
	assign frame_ok  = cs_rise & (s_q.count == FRAME_LEN);
	assign op        = s_q.shift[OP_MSB:OP_LSB];

	always_comb
	begin
		s_d = s_q;
		s_d.sclk_sync = {s_q.sclk_sync[1:0], SCLK};
		s_d.cs_sync   = {s_q.cs_sync[1:0], CHIP_SELECT_LOW_N};
		s_d.sdi_sync  = {s_q.sdi_sync[1:0], SDI};
		// bits shift in only on a sclk rise while chip select is low; other pins are ignored
		if (cs_low && sclk_rise)
		begin
			s_d.shift = {s_q.shift[FRAME_BITS-2:0], s_q.sdi_sync[2]};
			// one past a full frame marks it too long, so it stays refused
			if (s_q.count <= FRAME_LEN)
				s_d.count = s_q.count + 7'h01;
		end
		if (cs_rise)
		begin
			s_d.count = '0;
			if (s_q.count == FRAME_LEN)
			begin
				unique case (op)
					OP_CONFIG:
					begin
						s_d.config_reg = s_q.shift[DATA_BITS-1:0];
						// clearing the sleep bit wakes; nothing else reloads
						s_d.sleep = s_q.shift[SLEEP_POS];
					end
					OP_DATA1: s_d.data1 = s_q.shift[DATA_BITS-1:0];
					OP_DATA2: s_d.data2 = s_q.shift[DATA_BITS-1:0];
					OP_START:
						if (!s_q.sleep && s_q.tx == SSWS_IDLE)
						begin
							s_d.tx     = SSWS_SEND1;
							s_d.tx_buf = s_q.data1;
							s_d.tx_idx = 6'(DATA_BITS - 1);
							s_d.bdiv   = '0;
						end
					default: ;
				endcase
			end
		end
		// ****************************************
		// lf bit sender, one bit per divider pulse
		// ****************************************
		if (s_q.tx != SSWS_IDLE)
		begin
			s_d.lf_out = s_q.tx_buf[s_q.tx_idx]; // msb first
			if (s_q.bdiv == BDIV_W'(BIT_CYCLES - 1))
			begin
				s_d.bdiv = '0;
				if (s_q.tx_idx == 6'h00)
				begin
					if (s_q.tx == SSWS_SEND1)
					begin
						s_d.tx     = SSWS_SEND2;
						s_d.tx_buf = s_q.data2;
						s_d.tx_idx = 6'(DATA_BITS - 1);
					end
					else
						s_d.tx = SSWS_IDLE;
				end
				else
					s_d.tx_idx = s_q.tx_idx - 6'h01;
			end
			else
				s_d.bdiv = s_q.bdiv + BDIV_W'(1);
		end
		else
			s_d.lf_out = 1'b0;
		// sleep cuts a running transmission short, the lf output is tri-stated anyway
		if (s_d.sleep)
			s_d.tx = SSWS_IDLE;
	end

	always_ff @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			s_q <= '0;
			s_q.sclk_sync <= 3'h0;
			s_q.cs_sync   <= 3'h7;
			s_q.shift     <= SHIFT_RESET;
			s_q.sleep     <= 1'b1;
			s_q.tx        <= SSWS_IDLE;
		end
		else
			s_q <= s_d;
	end

	// ****************************************
	// outputs
	// ****************************************
	// sdo shifts the frame back msb first; released outside chip select
	assign SDO      = s_q.shift[FRAME_BITS-1];
	assign SDO_OE_N = ~cs_low;
	assign LF_OUT   = s_q.lf_out;
	assign LF_OE_N  = s_q.sleep; // tri-stated in sleep
	always_comb
	begin
		unique case (s_q.tx)
			SSWS_SEND1: STATUS.mode = MODE_DATA1;
			SSWS_SEND2: STATUS.mode = MODE_DATA2;
			default:    STATUS.mode = MODE_READY;
		endcase
		STATUS.sleep = s_q.sleep;
	end

	// ****************************************
	// checks
	// ****************************************
	a_reset_sleep: assert property (@(posedge SYS_CLK) $fell(RESET) |-> STATUS.sleep)
		else $error("not asleep after reset");
	a_short_frame: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(cs_rise && s_q.count != FRAME_LEN) |=> $stable(s_q.sleep))
		else $error("short frame changed sleep");
	a_wake_bit: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(frame_ok && op == OP_CONFIG && !s_q.shift[SLEEP_POS])
		|=> !STATUS.sleep)
		else $error("wake write ignored");
	a_data_kept: assert property (@(posedge SYS_CLK) disable iff (RESET)
		$fell(s_q.sleep) |-> $stable(s_q.data1) && $stable(s_q.data2))
		else $error("data lost at wake");
	a_msb_first: assert property (@(posedge SYS_CLK) disable iff (RESET)
		$rose(s_q.tx == SSWS_SEND1) |=> LF_OUT == s_q.data1[DATA_BITS-1])
		else $error("first lf bit not msb");
	a_mode_code: assert property (@(posedge SYS_CLK) disable iff (RESET)
		$rose(s_q.tx == SSWS_SEND2)
		|-> $past(s_q.tx) == SSWS_SEND1 && $past(s_q.tx_idx) == 6'h00
		&& STATUS.mode == MODE_DATA2)
		else $error("data 2 not sent right after data 1");
	a_sleep_tri: assert property (@(posedge SYS_CLK) disable iff (RESET)
		STATUS.sleep |-> LF_OE_N && s_q.tx == SSWS_IDLE)
		else $error("driving while asleep");
	a_shift_clear: assert property (@(posedge SYS_CLK) $fell(RESET) |-> s_q.shift == '0)
		else $error("shift not cleared");

	// ****************************************
	// frame and sender checks
	// ****************************************
	a_long_frame: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(cs_rise && s_q.count > FRAME_LEN)
		|=> $stable(s_q.sleep) && $stable(s_q.config_reg) && $stable(s_q.data1))
		else $error("long frame was acted on");
	a_count_mark: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(cs_low && sclk_rise && s_q.count == FRAME_LEN)
		|=> s_q.count == FRAME_LEN + 7'h01)
		else $error("bit past a full frame not marked");
	a_count_clear: assert property (@(posedge SYS_CLK) disable iff (RESET)
		cs_rise
		|=> s_q.count == 7'h00)
		else $error("bit count not cleared at frame end");
	a_config_store: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(frame_ok && op == OP_CONFIG)
		|=> s_q.sleep == s_q.config_reg[SLEEP_POS])
		else $error("sleep flag differs from stored bit");
	a_start_asleep: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(frame_ok && op == OP_START && s_q.sleep)
		|=> s_q.tx == SSWS_IDLE)
		else $error("start obeyed while asleep");
	a_start_go: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(frame_ok && op == OP_START && !s_q.sleep && s_q.tx == SSWS_IDLE)
		|=> STATUS.mode == MODE_DATA1 && s_q.tx_buf == s_q.data1)
		else $error("start not obeyed");
	a_lf_quiet: assert property (@(posedge SYS_CLK) disable iff (RESET)
		s_q.tx == SSWS_IDLE
		|=> !LF_OUT)
		else $error("lf output active while idle");
	a_bit_time: assert property (@(posedge SYS_CLK) disable iff (RESET)
		s_q.tx != SSWS_IDLE
		|-> s_q.bdiv < BDIV_W'(BIT_CYCLES))
		else $error("bit divider out of range");
	a_sleep_entry: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(frame_ok && op == OP_CONFIG && s_q.shift[SLEEP_POS])
		|=> STATUS.sleep && LF_OE_N && s_q.tx == SSWS_IDLE)
		else $error("sleep write not obeyed");

endmodule : ssws_top

`default_nettype wire

// File: inc/ssws_pkg.sv
// shared constants and carrier types for the sleep/wake sequencer
// assumes a single 100 MHz system clock and no software register bus
`default_nettype none

package ssws_pkg;

	// ****************************************
	// frame layout
	// ****************************************
	localparam int FRAME_BITS = 64;
	localparam int CMD_BITS   = 8;
	localparam int DATA_BITS  = 56;
	localparam int CNT_W      = 7;
	localparam logic [CNT_W-1:0] FRAME_LEN = 7'h40;
	localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 64'h0000000000000000;

	// ****************************************
	// 3-bit command codes and field positions
	// ****************************************
	localparam logic [2:0] OP_NONE    = 3'h0;
	localparam logic [2:0] OP_CONFIG  = 3'h1;
	localparam logic [2:0] OP_DATA1   = 3'h3;
	localparam logic [2:0] OP_DATA2   = 3'h4;
	localparam logic [2:0] OP_START   = 3'h5;
	localparam int OP_MSB    = 62;
	localparam int OP_LSB    = 60;
	localparam int SLEEP_POS = 0;

	// ****************************************
	// status encodings
	// ****************************************
	localparam logic [1:0] MODE_READY = 2'h0;
	localparam logic [1:0] MODE_DATA1 = 2'h2;
	localparam logic [1:0] MODE_DATA2 = 2'h3;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ        = 100;
	localparam int BIT_TIME_NS    = 1000;
	localparam int BIT_CYCLES     = (BIT_TIME_NS * CLK_MHZ) / 1000;
	localparam int BDIV_W         = 7;

	typedef enum logic [1:0] {SSWS_IDLE, SSWS_SEND1, SSWS_SEND2} ssws_tx_type;

	typedef struct packed {
		logic [2:0] sclk_sync;
		logic [2:0] cs_sync;
		logic [2:0] sdi_sync;
		logic [FRAME_BITS-1:0] shift;
		logic [CNT_W-1:0] count;
		logic [DATA_BITS-1:0] config_reg;
		logic [DATA_BITS-1:0] data1;
		logic [DATA_BITS-1:0] data2;
		logic sleep;
		ssws_tx_type tx;
		logic [DATA_BITS-1:0] tx_buf;
		logic [5:0] tx_idx;
		logic [BDIV_W-1:0] bdiv;
		logic lf_out;
	} ssws_state_type;

	typedef struct packed {
		logic [1:0] mode;
		logic       sleep;
	} ssws_status_type;

endpackage : ssws_pkg

`default_nettype wire

// File: sim/ssws_host_model.sv
// host side spi master model for the sleep/wake sequencer
// assumes the bench calls its tasks just after a rising system clock edge
`timescale 1ns/1ps
`default_nettype none

module ssws_host_model
(
	input  wire logic   clk,
	input  wire logic   sdo,
	output logic        sclk,
	output logic        cs_n,
	output logic        sdi,
	output logic [63:0] rx
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi  = 1'b0;
		rx   = 64'h0;
	end

	task automatic gap(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : gap

	// half periods of 5 clocks keep the pin synchronisers comfortable
	task automatic send(input logic [63:0] w, input int len);
		cs_n = 1'b0;
		gap(5);
		for (int i = 0; i < len; i++)
		begin
			sdi = (i < 64) ? w[63-i] : 1'b0;
			gap(5);
			// reply bit stands until the design sees the next rise
			if (i < 64)
				rx[63-i] = sdo;
			sclk = 1'b1;
			gap(5);
			sclk = 1'b0;
		end
		gap(5);
		cs_n = 1'b1;
		sdi  = ~sdi;
		gap(12);
	endtask : send
endmodule : ssws_host_model

`default_nettype wire

// File: sim/test_ssws_top.sv
// self-checking bench for the sleep/wake sequencer
// assumes the host model drives every spi pin of the design
`timescale 1ns/1ps
`default_nettype none

module test_ssws_top;
	import ssws_pkg::*;
	logic            sys_clk;
	logic            reset;
	logic            sclk, cs_n, sdi, sdo, sdo_oe_n, lf_out, lf_oe_n;
	ssws_status_type status;
	int              error_cnt = 0;
	int              checks_done = 0;
	int              seed = 52;
	int              cyc = 0;
	logic [55:0]     cfg, d1, d2;
	logic [63:0]     rx;

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	ssws_top i_ssws_top (.SYS_CLK(sys_clk), .RESET(reset), .SCLK(sclk),
		.CHIP_SELECT_LOW_N(cs_n), .SDI(sdi), .SDO(sdo), .SDO_OE_N(sdo_oe_n),
		.LF_OUT(lf_out), .LF_OE_N(lf_oe_n), .STATUS(status));
	ssws_host_model i_ssws_host_model (.clk(sys_clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n),
		.sdi(sdi), .rx(rx));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [63:0] frame(input logic [2:0] op, input logic [55:0] d);
		return {1'b0, op, 4'h0, d};
	endfunction : frame

	function automatic logic [55:0] rnd56();
		logic [63:0] r;
		r = {$random(seed), $random(seed)};
		return r[55:0];
	endfunction : rnd56

	// samples mid bit, lf bit time is 100 clocks
	task automatic play(input logic [55:0] a, input logic [55:0] b);
		chk(status.mode, MODE_DATA1);
		i_ssws_host_model.gap(40);
		for (int i = 0; i < 112; i++)
		begin
			if (i == 56)
				chk(status.mode, MODE_DATA2);
			chk(lf_out, (i < 56) ? a[55-i] : b[111-i]);
			i_ssws_host_model.gap(100);
		end
		chk(status.mode, MODE_READY);
	endtask : play

	task automatic final_report;
		if (error_cnt == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	initial
	begin
		reset = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 reset = 1'b0;
		i_ssws_host_model.gap(4);
		chk(status, 3'h1);
		chk({sdo_oe_n, lf_oe_n, sdo}, 3'h6);
		i_ssws_host_model.send(frame(OP_CONFIG, 56'h0), 1 + ($unsigned($random(seed)) % 63));
		chk(rx, 64'h0);
		// the last 64 of these 65 bits form a valid wake write
		i_ssws_host_model.send(frame(OP_CONFIG, 56'h0) >> 1, 65);
		chk(status.sleep, 1'b1);
		i_ssws_host_model.send(frame(OP_START, 56'h0), 64);
		chk(status, 3'h1);
		i_ssws_host_model.send(frame(OP_CONFIG, 56'h0), 64);
		chk({status, lf_oe_n}, 4'h0);
		cfg = rnd56() & 56'hFFFFFFFFFFFFFE;
		i_ssws_host_model.send(frame(OP_CONFIG, cfg), 64);
		d1 = rnd56();
		d2 = rnd56();
		i_ssws_host_model.send(frame(OP_DATA1, d1), 64);
		i_ssws_host_model.send(frame(OP_DATA2, d2), 64);
		chk(rx, frame(OP_DATA1, d1));
		i_ssws_host_model.gap(6400);
		i_ssws_host_model.send(frame(OP_START, 56'h0), 64);
		play(d1, d2);
		i_ssws_host_model.send(frame(OP_CONFIG, cfg | 56'h1), 64);
		chk({status, lf_oe_n}, 4'h3);
		i_ssws_host_model.send(frame(OP_CONFIG, cfg), 64);
		i_ssws_host_model.gap(6400);
		i_ssws_host_model.send(frame(OP_START, 56'h0), 64);
		play(d1, d2);
		// sleeping in mid transmission must silence the lf output at once
		i_ssws_host_model.send(frame(OP_START, 56'h0), 64);
		i_ssws_host_model.gap(200);
		i_ssws_host_model.send(frame(OP_CONFIG, cfg | 56'h1), 64);
		chk({status, lf_oe_n, lf_out}, 5'h06);
		final_report();
	end

	// whole run needs about 45000 clocks
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 70000)
		begin
			error_cnt++;
			final_report();
		end
	end
endmodule : test_ssws_top

`default_nettype wire
